//--- mig_cfg.svh
// Constants of the mode indexed general purpose port block.
// Assumes it is included by the design files, which use the names only.
`ifndef MIG_CFG_SVH
`define MIG_CFG_SVH

// Data memory addresses of the three pin data registers.
`define MIG_ADDR_PORT_A   8'h05
`define MIG_ADDR_PORT_B   8'h06
`define MIG_ADDR_PORT_C   8'h07

// Mode index values that select a control register.
`define MIG_MODE_CMP      8'h08
`define MIG_MODE_WKPND    8'h09
`define MIG_MODE_WKEDGE   8'h0a
`define MIG_MODE_WKEN     8'h0b
`define MIG_MODE_HYST     8'h0c
`define MIG_MODE_LEVEL    8'h0d
`define MIG_MODE_PULLUP   8'h0e
`define MIG_MODE_DIR      8'h0f

// Reset values.
`define MIG_MODE_RESET    8'h0f
`define MIG_CFG_RESET     8'hff
`define MIG_DATA_RESET    8'h00
`define MIG_READ_UNMAPPED 8'h00

// Pin counts of the three ports.
`define MIG_WIDTH_A       4
`define MIG_WIDTH_BC      8
`define MIG_PIN_TOTAL     20

`endif

//--- mig_pkg.sv
// Types shared by the mode indexed general purpose port block.
// Assumes the constants header is included where numbers are needed.
`default_nettype none
package mig_pkg;

    // Port that a port-control move addresses.
    typedef enum logic [1:0] {
        MIG_PORT_A,
        MIG_PORT_B,
        MIG_PORT_C,
        MIG_PORT_NONE
    } mig_port_e;

    // Data memory access from the CPU core.
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle.
        logic       rd;    // Read strobe, one cycle.
        logic [7:0] addr;  // Data memory address.
        logic [7:0] wdata; // Write data.
    } mig_dm_req_s;

    // Port-control move from the working register.
    typedef struct packed {
        logic       move;  // Move strobe, one cycle.
        mig_port_e  port;  // Target port.
        logic [7:0] w;     // Working register value.
    } mig_ctl_req_s;

    // Mode index load.
    typedef struct packed {
        logic       wr;    // Load strobe, one cycle.
        logic [7:0] wdata; // Literal or working register value.
    } mig_mode_req_s;

    // Configuration of one port; bit 0 is the lowest pin.
    typedef struct packed {
        logic [7:0] dir;        // 1 input, 0 output.
        logic [7:0] drive;      // Inverse of dir, the pin output enable.
        logic [7:0] pullup_dis; // 1 pull-up disconnected.
        logic [7:0] thresh;     // 1 TTL, 0 CMOS.
        logic [7:0] hyst_dis;   // 1 Schmitt trigger off.
        logic [7:0] wake_dis;   // 1 wakeup off.
        logic [7:0] wake_edge;  // 1 rising, 0 falling.
    } mig_cfg_s;

endpackage
`default_nettype wire

//--- mig_sync.sv
// Two flip-flop synchroniser for the pin inputs.
// Assumes the inputs are asynchronous pins and the reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
module mig_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    // Both stages live in one state record.
    typedef struct packed {
        logic [WIDTH-1:0] meta; // First stage, read only by the second.
        logic [WIDTH-1:0] safe; // Second stage, the settled level.
    } mig_sync_s;

    mig_sync_s st;      // Registered state.
    mig_sync_s next_st; // Next state.

    // The first stage feeds the second stage and nothing else.
    always_comb begin
        next_st.meta = i_async;
        next_st.safe = st.meta;
    end

    // Registered on every edge, cleared by the synchronous reset.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.safe;
endmodule
`default_nettype wire

//--- mig_port_bank.sv
// Control registers of one port, written through the mode index.
// Assumes the caller gives a one-cycle write already decoded for this port.
`timescale 1ns/1ps
`default_nettype none
`include "mig_cfg.svh"
module mig_port_bank #(
    parameter int WIDTH    = 8,
    parameter bit HAS_HYST = 1'b1,
    parameter bit HAS_WAKE = 1'b0
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_wr,
    input  wire logic [7:0]       i_mode,
    input  wire logic [7:0]       i_w,
    output var  mig_pkg::mig_cfg_s o_cfg
);
    import mig_pkg::*;

    // Pins that exist; bits above stay at their reset value.
    localparam logic [7:0] PIN_MASK = 8'hff >> (8 - WIDTH);

    mig_cfg_s   st;      // Registered configuration.
    mig_cfg_s   next_st; // Next configuration.
    logic [7:0] val;     // Written value with the unused bits kept high.

    // A move at a mode that this port lacks changes nothing.
    always_comb begin
        val     = (i_w & PIN_MASK) | ~PIN_MASK;
        next_st = st;
        if (i_wr) begin
            case (i_mode)
                `MIG_MODE_DIR: begin
                    next_st.dir   = val;
                    next_st.drive = ~val;
                end
                `MIG_MODE_PULLUP: begin
                    next_st.pullup_dis = val;
                end
                `MIG_MODE_LEVEL: begin
                    next_st.thresh = val;
                end
                `MIG_MODE_HYST: begin
                    if (HAS_HYST) begin
                        next_st.hyst_dis = val;
                    end
                end
                `MIG_MODE_WKEN: begin
                    if (HAS_WAKE) begin
                        next_st.wake_dis = val;
                    end
                end
                `MIG_MODE_WKEDGE: begin
                    if (HAS_WAKE) begin
                        next_st.wake_edge = val;
                    end
                end
                default: begin
                    next_st = st;
                end
            endcase
        end
    end

    // Every control register powers up all ones except drive, which is zero, so every pin is an input.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st       <= '1;
            st.drive <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_cfg = st;

    a_edge_write: assert property (@(posedge i_clock) disable iff (i_rst)
        (HAS_WAKE && i_wr && i_mode == `MIG_MODE_WKEDGE)
        |=> st.wake_edge == $past(val))
        else $error("wake edge register missed a write");
    a_hyst_absent: assert property (@(posedge i_clock) disable iff (i_rst)
        !HAS_HYST |-> st.hyst_dis == `MIG_CFG_RESET)
        else $error("absent hysteresis register changed");
endmodule
`default_nettype wire

//--- mig_ports.sv
// Top of the mode indexed general purpose port block: three ports.
// Assumes the CPU core gives one-cycle strobes on the same clock and
// that the wakeup pending and comparator latches live outside.
`timescale 1ns/1ps
`default_nettype none
`include "mig_cfg.svh"
module mig_ports (
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RST,
    input  wire mig_pkg::mig_dm_req_s  I_DM,
    input  wire mig_pkg::mig_ctl_req_s I_CTL,
    input  wire mig_pkg::mig_mode_req_s I_MODE,
    input  wire logic [7:0]            I_PB_WAKEUP_PENDING,
    input  wire logic [7:0]            I_PB_COMPARATOR_CTL,
    input  wire logic [3:0]            I_PA_PIN,
    input  wire logic [7:0]            I_PB_PIN,
    input  wire logic [7:0]            I_PC_PIN,
    output var  logic [7:0]            O_DM_RDATA,
    output var  logic                  O_DM_RVALID,
    output var  logic [7:0]            O_MODE,
    output var  logic [7:0]            O_XCHG_DATA,
    output var  logic                  O_XCHG_VALID,
    output var  logic [7:0]            O_XCHG_WDATA,
    output var  logic                  O_PB_WAKEUP_PENDING_WR,
    output var  logic                  O_PB_COMPARATOR_CTL_WR,
    output var  logic [3:0]            O_PA_OUT,
    output var  logic [3:0]            O_PA_OE,
    output var  logic [7:0]            O_PB_OUT,
    output var  logic [7:0]            O_PB_OE,
    output var  logic [7:0]            O_PC_OUT,
    output var  logic [7:0]            O_PC_OE,
    output var  mig_pkg::mig_cfg_s     O_PA_CFG,
    output var  mig_pkg::mig_cfg_s     O_PB_CFG,
    output var  mig_pkg::mig_cfg_s     O_PC_CFG
);
    import mig_pkg::*;

    // All state of the top in one record.
    typedef struct packed {
        logic [7:0] mode;     // Mode index.
        logic [3:0] a_out;    // First port output latch.
        logic [7:0] b_out;    // Second port output latch.
        logic [7:0] c_out;    // Third port output latch.
        logic [7:0] rdata;    // Read answer.
        logic       rvalid;   // Read answer strobe.
        logic [7:0] xchg;     // Contents returned by an exchange.
        logic       xvalid;   // Exchange strobe.
        logic [7:0] xwdata;   // Working value handed to the latch.
        logic       wkpnd_wr; // Pending latch takes xwdata.
        logic       cmp_wr;   // Comparator latch takes xwdata.
    } mig_top_s;

    mig_top_s   st;       // Registered state.
    mig_top_s   next_st;  // Next state.
    logic [19:0] pins;    // Settled pin levels, A low then B then C.
    logic       wr_a;     // Control move aimed at the first port.
    logic       wr_b;     // Control move aimed at the second port.
    logic       wr_c;     // Control move aimed at the third port.
    mig_cfg_s   cfg_a;    // First port configuration.
    mig_cfg_s   cfg_b;    // Second port configuration.
    mig_cfg_s   cfg_c;    // Third port configuration.

    // Pins are asynchronous, so they settle through two stages first.
    // The two cycles of delay are why a read right after a write may
    // still show the old level.
    mig_sync #(
        .WIDTH (`MIG_PIN_TOTAL)
    ) u_sync (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .i_async ({I_PC_PIN, I_PB_PIN, I_PA_PIN}),
        .o_sync  (pins)
    );

    // The move is steered by port; each bank decodes the mode itself.
    // A move with no port named reaches no bank and so writes nothing.
    always_comb begin
        wr_a = I_CTL.move && (I_CTL.port == MIG_PORT_A);
        wr_b = I_CTL.move && (I_CTL.port == MIG_PORT_B);
        wr_c = I_CTL.move && (I_CTL.port == MIG_PORT_C);
    end

    // First port: four pins, no Schmitt trigger, no wakeup.
    mig_port_bank #(
        .WIDTH    (`MIG_WIDTH_A),
        .HAS_HYST (1'b0),
        .HAS_WAKE (1'b0)
    ) u_bank_a (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .i_wr    (wr_a),
        .i_mode  (st.mode),
        .i_w     (I_CTL.w),
        .o_cfg   (cfg_a)
    );

    // Second port: eight pins, Schmitt trigger and wakeup.
    mig_port_bank #(
        .WIDTH    (`MIG_WIDTH_BC),
        .HAS_HYST (1'b1),
        .HAS_WAKE (1'b1)
    ) u_bank_b (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .i_wr    (wr_b),
        .i_mode  (st.mode),
        .i_w     (I_CTL.w),
        .o_cfg   (cfg_b)
    );

    // Third port: eight pins, Schmitt trigger, no wakeup.
    mig_port_bank #(
        .WIDTH    (`MIG_WIDTH_BC),
        .HAS_HYST (1'b1),
        .HAS_WAKE (1'b0)
    ) u_bank_c (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .i_wr    (wr_c),
        .i_mode  (st.mode),
        .i_w     (I_CTL.w),
        .o_cfg   (cfg_c)
    );

    // Next state of the data latches, the mode index and the answers.
    always_comb begin
        next_st          = st;
        next_st.rvalid   = 1'b0;
        next_st.xvalid   = 1'b0;
        next_st.wkpnd_wr = 1'b0;
        next_st.cmp_wr   = 1'b0;

        // The mode index changes only on its own load strobe.
        // Reserved values are kept as given; the banks then ignore moves.
        if (I_MODE.wr) begin
            next_st.mode = I_MODE.wdata;
        end

        // Data writes land in the latch whatever the direction; an
        // input pin simply does not show it until it turns output.
        if (I_DM.wr) begin
            case (I_DM.addr)
                `MIG_ADDR_PORT_A: begin
                    next_st.a_out = I_DM.wdata[3:0];
                end
                `MIG_ADDR_PORT_B: begin
                    next_st.b_out = I_DM.wdata;
                end
                `MIG_ADDR_PORT_C: begin
                    next_st.c_out = I_DM.wdata;
                end
                default: begin
                    next_st.c_out = st.c_out; // Not ours.
                end
            endcase
        end

        // Reads show the pins, never the latch; the upper nibble of the
        // first port reads zero.
        if (I_DM.rd) begin
            next_st.rvalid = 1'b1;
            case (I_DM.addr)
                `MIG_ADDR_PORT_A: begin
                    next_st.rdata = {4'h0, pins[3:0]};
                end
                `MIG_ADDR_PORT_B: begin
                    next_st.rdata = pins[11:4];
                end
                `MIG_ADDR_PORT_C: begin
                    next_st.rdata = pins[19:12];
                end
                default: begin
                    next_st.rdata = `MIG_READ_UNMAPPED;
                end
            endcase
        end

        // Second port at the pending or comparator index: hand back the
        // latch contents and pass the working value out to be stored.
        if (wr_b && st.mode == `MIG_MODE_WKPND) begin
            next_st.xvalid   = 1'b1;
            next_st.xchg     = I_PB_WAKEUP_PENDING;
            next_st.xwdata   = I_CTL.w;
            next_st.wkpnd_wr = 1'b1;
        end else if (wr_b && st.mode == `MIG_MODE_CMP) begin
            next_st.xvalid = 1'b1;
            next_st.xchg   = I_PB_COMPARATOR_CTL;
            next_st.xwdata = I_CTL.w;
            next_st.cmp_wr = 1'b1;
        end
    end

    // Registered every edge; the mode index powers up at the direction
    // registers so that the first moves set directions.
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            st       <= '0;
            st.mode  <= `MIG_MODE_RESET;
            // The first port latch has four bits, so the reset byte is cut.
            st.a_out <= 4'(`MIG_DATA_RESET);
            st.b_out <= `MIG_DATA_RESET;
            st.c_out <= `MIG_DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops of this module or of a bank.
    assign O_DM_RDATA             = st.rdata;
    assign O_DM_RVALID            = st.rvalid;
    assign O_MODE                 = st.mode;
    assign O_XCHG_DATA            = st.xchg;
    assign O_XCHG_VALID           = st.xvalid;
    assign O_XCHG_WDATA           = st.xwdata;
    assign O_PB_WAKEUP_PENDING_WR = st.wkpnd_wr;
    assign O_PB_COMPARATOR_CTL_WR = st.cmp_wr;
    assign O_PA_OUT               = st.a_out;
    assign O_PB_OUT               = st.b_out;
    assign O_PC_OUT               = st.c_out;
    assign O_PA_OE                = cfg_a.drive[3:0];
    assign O_PB_OE                = cfg_b.drive;
    assign O_PC_OE                = cfg_c.drive;
    assign O_PA_CFG               = cfg_a;
    assign O_PB_CFG               = cfg_b;
    assign O_PC_CFG               = cfg_c;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    // Reset checks run with the reset itself, so they carry their own clock
    // and switch the default disable off; otherwise they are never tried.
    a_mode_reset: assert property (@(posedge I_CLOCK) disable iff (1'b0)
        I_RST |=> O_MODE == `MIG_MODE_RESET)
        else $error("mode index not 0Fh after reset");
    a_cfg_reset: assert property (@(posedge I_CLOCK) disable iff (1'b0)
        I_RST |=> (O_PB_CFG.dir == `MIG_CFG_RESET && O_PB_OE == 8'h00))
        else $error("port configuration not all ones after reset");
    a_mode_hold: assert property (
        !I_MODE.wr |=> $stable(O_MODE))
        else $error("mode index changed without a load");
    a_mode_load: assert property (
        I_MODE.wr |=> O_MODE == $past(I_MODE.wdata))
        else $error("mode index load lost");

    // Data bus: writes land in the latch, reads answer one cycle later.
    a_data_write: assert property (
        (I_DM.wr && I_DM.addr == `MIG_ADDR_PORT_B)
        |=> O_PB_OUT == $past(I_DM.wdata))
        else $error("second port latch missed a write");
    a_low_nibble: assert property (
        (I_DM.wr && I_DM.addr == `MIG_ADDR_PORT_A)
        |=> O_PA_OUT == $past(I_DM.wdata[3:0]))
        else $error("first port latch missed a write");
    a_pin_read: assert property (
        (I_DM.rd && I_DM.addr == `MIG_ADDR_PORT_C)
        |=> (O_DM_RVALID && O_DM_RDATA == $past(pins[19:12])))
        else $error("read did not return the pin levels");
    a_third_latch: assert property (
        (I_DM.wr && I_DM.addr == `MIG_ADDR_PORT_C)
        |=> O_PC_OUT == $past(I_DM.wdata))
        else $error("third port latch missed a write");
    a_first_read: assert property (
        (I_DM.rd && I_DM.addr == `MIG_ADDR_PORT_A)
        |=> O_DM_RDATA == {4'h0, $past(pins[3:0])})
        else $error("first port read showed the upper nibble");
    a_unmapped_read: assert property (
        (I_DM.rd && I_DM.addr > `MIG_ADDR_PORT_C)
        |=> (O_DM_RVALID && O_DM_RDATA == `MIG_READ_UNMAPPED))
        else $error("unmapped read did not answer zero");

    // Control moves: the mode index as it stands at the move decides.
    a_dir_drive: assert property (
        (wr_c && O_MODE == `MIG_MODE_DIR)
        |=> (O_PC_CFG.dir == $past(I_CTL.w) && O_PC_OE == ~$past(I_CTL.w)))
        else $error("direction write did not steer the enables");
    a_mode_steer: assert property (
        (wr_a && O_MODE == `MIG_MODE_PULLUP)
        |=> O_PA_CFG.pullup_dis[3:0] == $past(I_CTL.w[3:0]))
        else $error("pull-up register missed a move");
    a_level_write: assert property (
        (wr_b && O_MODE == `MIG_MODE_LEVEL)
        |=> O_PB_CFG.thresh == $past(I_CTL.w))
        else $error("threshold register missed a move");
    a_wake_enable: assert property (
        (wr_b && O_MODE == `MIG_MODE_WKEN)
        |=> O_PB_CFG.wake_dis == $past(I_CTL.w))
        else $error("wakeup enable register missed a move");
    a_hyst_write: assert property (
        (wr_c && O_MODE == `MIG_MODE_HYST)
        |=> O_PC_CFG.hyst_dis == $past(I_CTL.w))
        else $error("hysteresis register missed a move");
    a_no_reg: assert property (
        (wr_a && O_MODE == `MIG_MODE_WKEN && !I_DM.wr) |=> $stable(O_PA_CFG))
        else $error("move to a missing register changed state");

    // Exchanges answer one cycle after the move, and the strobe falls again
    // unless another move to the second port follows at once.
    a_exchange: assert property (
        (wr_b && O_MODE == `MIG_MODE_WKPND)
        |=> (O_XCHG_VALID && O_PB_WAKEUP_PENDING_WR
             && O_XCHG_DATA == $past(I_PB_WAKEUP_PENDING)
             && O_XCHG_WDATA == $past(I_CTL.w))
            ##1 (!O_XCHG_VALID || $past(wr_b)))
        else $error("exchange did not return pending contents");
    a_cmp_exchange: assert property (
        (wr_b && O_MODE == `MIG_MODE_CMP)
        |=> (O_XCHG_VALID && O_PB_COMPARATOR_CTL_WR
             && O_XCHG_DATA == $past(I_PB_COMPARATOR_CTL)))
        else $error("exchange did not return comparator contents");

    // Main scenarios that the bench is expected to reach.
    c_mode_then_move: cover property (I_MODE.wr ##1 I_CTL.move);
    c_port_read: cover property (I_DM.rd && I_DM.addr == `MIG_ADDR_PORT_A);
    c_cmp_exchange: cover property (O_PB_COMPARATOR_CTL_WR);
    c_pullup_move: cover property (wr_a && O_MODE == `MIG_MODE_PULLUP);
    c_unmapped_read: cover property (I_DM.rd && I_DM.addr > `MIG_ADDR_PORT_C);
endmodule
`default_nettype wire

//--- mig_pin_model.sv
// Pin side and outside latch model for the mode indexed port block.
// Assumes the bench gives the levels that outside parts put on pins.
`timescale 1ns/1ps
`default_nettype none
module mig_pin_model #(
    parameter logic [7:0] PEND_INIT = 8'h5a, // Arbitrary start value.
    parameter logic [7:0] CMP_INIT  = 8'h3c  // Arbitrary start value.
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic [19:0] i_out,
    input  wire logic [19:0] i_oe,
    input  wire logic [19:0] i_ext,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_pend_wr,
    input  wire logic        i_cmp_wr,
    output var  logic [19:0] o_pin,
    output var  logic [7:0]  o_pend,
    output var  logic [7:0]  o_cmp
);
    // A driven pin shows its latch, an input pin the outside level.
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
    // The latches take the working value only on their own strobe, so a
    // later exchange shows whether the block passed the right value out.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pend <= PEND_INIT;
            o_cmp  <= CMP_INIT;
        end else begin
            if (i_pend_wr) begin
                o_pend <= i_wdata;
            end
            if (i_cmp_wr) begin
                o_cmp <= i_wdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- mig_ports_tb.sv
// Self-checking bench for the mode indexed port block.
// Assumes the pin model stands on the pin side of the block.
`timescale 1ns/1ps
`default_nettype none
module mig_ports_tb;
    import mig_pkg::*;
    logic          I_CLOCK;    // Bench clock, 20 ns.
    logic          I_RST;      // Synchronous reset.
    mig_dm_req_s   dm;         // Data memory request.
    mig_ctl_req_s  ctl;        // Port-control move.
    mig_mode_req_s md;         // Mode index load.
    mig_cfg_s      ca, cb, cc; // Configuration outputs.
    logic [19:0]   out, oe, pin, ext;
    logic [7:0]    pend, cmp, rdat, xdat, xwd, mo, w, d, wa, db;
    logic          rv, xv, pwr, cwr;
    int            bad_count, check_count, cycles;

    initial begin
        I_CLOCK = 1'b0;
        forever #10 I_CLOCK = ~I_CLOCK;
    end

    // A hang ends the run as a mismatch; the tests need about 130.
    always @(posedge I_CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // Each request is raised at a falling edge and held for one edge.
    task automatic dm_op(logic wr, logic [7:0] a, logic [7:0] v);
        @(negedge I_CLOCK);
        dm = '{wr, !wr, a, v};
        @(negedge I_CLOCK);
        dm = '0;
    endtask

    task automatic mode_wr(logic [7:0] v);
        @(negedge I_CLOCK);
        md = '{1'b1, v};
        @(negedge I_CLOCK);
        md = '0;
    endtask

    task automatic move(mig_port_e p, logic [7:0] v);
        @(negedge I_CLOCK);
        ctl = '{1'b1, p, v};
        @(negedge I_CLOCK);
        ctl.move = 1'b0;
    endtask

    // Field picked by modes 0Ah to 0Eh; the struct runs edge first.
    function automatic logic [7:0] fld(mig_cfg_s c, int m);
        return c[8*(m-10) +: 8];
    endfunction

    // Level read back: latch where driven, outside level where input.
    function automatic logic [7:0] ep(logic [7:0] r, v, x);
        return (~r & v) | (r & x);
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    mig_ports mig_ports_inst (
        .I_CLOCK                (I_CLOCK),
        .I_RST                  (I_RST),
        .I_DM                   (dm),
        .I_CTL                  (ctl),
        .I_MODE                 (md),
        .I_PB_WAKEUP_PENDING    (pend),
        .I_PB_COMPARATOR_CTL    (cmp),
        .I_PA_PIN               (pin[3:0]),
        .I_PB_PIN               (pin[11:4]),
        .I_PC_PIN               (pin[19:12]),
        .O_DM_RDATA             (rdat),
        .O_DM_RVALID            (rv),
        .O_MODE                 (mo),
        .O_XCHG_DATA            (xdat),
        .O_XCHG_VALID           (xv),
        .O_XCHG_WDATA           (xwd),
        .O_PB_WAKEUP_PENDING_WR (pwr),
        .O_PB_COMPARATOR_CTL_WR (cwr),
        .O_PA_OUT               (out[3:0]),
        .O_PA_OE                (oe[3:0]),
        .O_PB_OUT               (out[11:4]),
        .O_PB_OE                (oe[11:4]),
        .O_PC_OUT               (out[19:12]),
        .O_PC_OE                (oe[19:12]),
        .O_PA_CFG               (ca),
        .O_PB_CFG               (cb),
        .O_PC_CFG               (cc)
    );

    mig_pin_model mig_pin_model_inst (
        .i_clock   (I_CLOCK),
        .i_rst     (I_RST),
        .i_out     (out),
        .i_oe      (oe),
        .i_ext     (ext),
        .i_wdata   (xwd),
        .i_pend_wr (pwr),
        .i_cmp_wr  (cwr),
        .o_pin     (pin),
        .o_pend    (pend),
        .o_cmp     (cmp)
    );

    initial begin
        I_RST = 1'b1;
        dm = '0;
        ctl = '{1'b0, MIG_PORT_NONE, 8'h00};
        md = '0;
        ext = '0;
        void'($urandom(32'h8bd0));
        repeat (4) @(negedge I_CLOCK);
        I_RST = 1'b0;
        chk("mode", 8'h0f, mo);
        chk("b dir", 8'hff, cb.dir);
        chk("c level", 8'hff, cc.thresh);
        chk("b oe", 8'h00, oe[11:4]);
        // Latch written while the pins are inputs, then pins 1 and 3 driven.
        wa = 8'($urandom);
        dm_op(1'b1, 8'h05, wa);
        chk("a oe", 8'h00, {4'h0, oe[3:0]});
        move(MIG_PORT_A, 8'h05);
        chk("a dir", 8'hf5, ca.dir);
        chk("a oe", 8'h0a, {4'h0, oe[3:0]});
        chk("a out", {4'h0, wa[3:0]}, {4'h0, out[3:0]});
        for (int i = 0; i < 4; i++) begin
            w = 8'($urandom);
            move(MIG_PORT_B, w);
            move(MIG_PORT_C, ~w);
            dm_op(1'b1, 8'h06, ~w);
            chk("b dir", w, cb.dir);
            chk("b oe", ~w, oe[11:4]);
            chk("c oe", w, oe[19:12]);
            chk("b out", ~w, out[11:4]);
        end
        // Reads return pin levels; each read is a single one, never an
        // overlapping read-modify-write pair.
        for (int i = 0; i < 3; i++) begin
            w = 8'($urandom);
            d = 8'($urandom);
            ext = 20'($urandom);
            move(MIG_PORT_B, w);
            dm_op(1'b1, 8'h06, d);
            repeat (3) @(negedge I_CLOCK);
            dm_op(1'b0, 8'h06, 8'h00);
            chk("b read", ep(w, d, ext[11:4]), rdat);
            chk("rvalid", 8'h01, {7'h0, rv});
            dm_op(1'b0, 8'h05, 8'h00);
            chk("a read", ep(8'h05, wa & 8'h0f, 8'(ext[3:0])), rdat);
        end
        db = w;
        dm_op(1'b1, 8'h08, 8'hff);
        chk("mode", 8'h0f, mo);
        chk("b out", d, out[11:4]);
        dm_op(1'b0, 8'h08, 8'h00);
        chk("unmapped", 8'h00, rdat);
        // One mode load serves moves to all three ports.
        for (int m = 10; m < 15; m++) begin
            mode_wr(8'(m));
            w = 8'($urandom);
            move(MIG_PORT_A, w);
            move(MIG_PORT_B, w);
            move(MIG_PORT_C, ~w);
            chk("mode", 8'(m), mo);
            chk("a fld", (m > 12) ? {4'hf, w[3:0]} : 8'hff, fld(ca, m));
            chk("b fld", w, fld(cb, m));
            chk("c fld", (m > 11) ? ~w : 8'hff, fld(cc, m));
        end
        // The index stays within 08h to 0Fh; refusals use a missing register and a move with no port.
        mode_wr(8'h0b);
        move(MIG_PORT_C, 8'h00);
        mode_wr(8'h0f);
        move(MIG_PORT_NONE, 8'h00);
        chk("c wake", 8'hff, cc.wake_dis);
        chk("b dir", db, cb.dir);
        chk("a dir", 8'hf5, ca.dir);
        for (int m = 8; m < 10; m++) begin
            mode_wr(8'(m));
            w = 8'($urandom);
            d = (m == 9) ? pend : cmp;
            move(MIG_PORT_B, w);
            chk("xchg data", d, xdat);
            chk("xchg valid", 8'h01, {7'h0, xv});
            @(negedge I_CLOCK);
            chk("latch", w, (m == 9) ? pend : cmp);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
